// [verilog/sct_pkg.sv]
// Purpose: constants for the steamer cook timer control
// Assumes: 100 MHz clock, keys and sensors are raw pins
// Notes: Summary of operation
package sct_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int SLOW_PER_S = 2;
  localparam int FAST_PER_S = 20;
  localparam int SLOW_HOLD_S = 5;
  localparam int BEEP_S = 4;
  localparam int MINUTE_S = 60;
  localparam int FLASH_HZ = 2;
  localparam int SLOW_TICKS = CLK_HZ / SLOW_PER_S;
  localparam int FAST_TICKS = CLK_HZ / FAST_PER_S;
  localparam int HOLD_TICKS = CLK_HZ * SLOW_HOLD_S;
  localparam int BEEP_TICKS = CLK_HZ * BEEP_S;
  localparam int FLASH_TICKS = CLK_HZ / (2 * FLASH_HZ);
  localparam logic [63:0] MINUTE_TICKS = 64'(CLK_HZ) * 64'(MINUTE_S);
  localparam logic [6:0] MAX_MIN = 7'h63;
  localparam logic [6:0] ZERO_MIN = 7'h00;
  localparam int BEEP_BIT = 23;
  typedef enum logic [1:0] {SCT_IDLE, SCT_TIMED, SCT_CONT} sct_mode_t;
endpackage : sct_pkg

// [verilog/sct_sync_if.sv]
// Purpose: carries synchronised pin levels between sct modules
// Assumes: single clock
// Notes: one bit per raw pin
interface sct_sync_if;
  logic [8:0] lvl;
  modport src (output lvl);
  modport dst (input lvl);
endinterface : sct_sync_if

// [verilog/sct_sync.sv]
// Purpose: two-flop synchroniser for all panel and sensor pins
// Assumes: pins are asynchronous to clock
// Notes: first stage read only by second stage
module sct_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic [8:0] pins,
  sct_sync_if.src sync
);
  logic [8:0] meta_ff;
  logic [8:0] lvl_ff;
  logic [8:0] nxt_meta;
  logic [8:0] nxt_lvl;

  always_comb begin
    nxt_meta = pins;
    nxt_lvl = meta_ff;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_ff <= 9'h000;
      lvl_ff <= 9'h000;
    end else begin
      meta_ff <= nxt_meta;
      lvl_ff <= nxt_lvl;
    end
  end

  assign sync.lvl = lvl_ff;
endmodule : sct_sync

// [verilog/sct_cook_timer.sv]
// Purpose: control panel sequencer for counter steam cooker
// Assumes: keys high while pressed, sensors high when active
// Notes: times are parameters so simulation can shorten them
module sct_cook_timer import sct_pkg::*; #(
  parameter int SLOW_T = SLOW_TICKS,
  parameter int FAST_T = FAST_TICKS,
  parameter int HOLD_T = HOLD_TICKS,
  parameter int BEEP_T = BEEP_TICKS,
  parameter int FLASH_T = FLASH_TICKS,
  parameter logic [63:0] MINUTE_T = MINUTE_TICKS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic key_power,
  input wire logic key_cont,
  input wire logic key_timed,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic door_open,
  input wire logic level_low,
  input wire logic at_temp,
  input wire logic overflow,
  output logic lamp_power,
  output logic lamp_cont,
  output logic lamp_timed,
  output logic lamp_status,
  output logic lamp_overflow,
  output logic lamp_water,
  output logic fill_valve,
  output logic heater_on,
  output logic condenser_on,
  output logic beeper,
  output logic [6:0] minutes,
  output logic display_blank
);
  // =====================================================
  // input synchronisation
  sct_sync_if sif();
  sct_sync u_sync (
    .clock(clock),
    .rst(rst),
    .pins({overflow, at_temp, level_low, door_open, key_down, key_up, key_timed, key_cont, key_power}),
    .sync(sif)
  );
  logic s_pwr;
  logic s_cont;
  logic s_timed;
  logic s_up;
  logic s_dn;
  logic s_door;
  logic s_low;
  logic s_hot;
  logic s_ovf;
  assign {s_ovf, s_hot, s_low, s_door, s_dn, s_up, s_timed, s_cont, s_pwr} = sif.lvl;

  // =====================================================
  // state
  logic [4:0] keys_ff;
  logic [4:0] nxt_keys;
  logic on_ff;
  logic nxt_on;
  sct_mode_t mode_ff;
  sct_mode_t nxt_mode;
  logic [6:0] min_ff;
  logic [6:0] nxt_min;
  logic fresh_ff;
  logic nxt_fresh;
  logic done_ff;
  logic nxt_done;
  logic [31:0] rep_ff;
  logic [31:0] nxt_rep;
  logic [31:0] hold_ff;
  logic [31:0] nxt_hold;
  logic [63:0] tick_ff;
  logic [63:0] nxt_tick;
  logic [31:0] beep_ff;
  logic [31:0] nxt_beep;
  logic [31:0] flash_cnt_ff;
  logic [31:0] nxt_flash_cnt;
  logic flash_ff;
  logic nxt_flash;
  logic lp_ff;
  logic nxt_lp;
  logic lc_ff;
  logic nxt_lc;
  logic lt_ff;
  logic nxt_lt;
  logic ls_ff;
  logic nxt_ls;
  logic lo_ff;
  logic nxt_lo;
  logic lw_ff;
  logic nxt_lw;
  logic fv_ff;
  logic nxt_fv;
  logic ht_ff;
  logic nxt_ht;
  logic cd_ff;
  logic nxt_cd;
  logic bp_ff;
  logic nxt_bp;
  logic bl_ff;
  logic nxt_bl;

  logic [4:0] press;
  logic steam_ok, counting, adj_step, fast;
  assign press = {s_dn, s_up, s_timed, s_cont, s_pwr} & ~keys_ff;

  // =====================================================
  // sequencing
  always_comb begin
    nxt_keys = {s_dn, s_up, s_timed, s_cont, s_pwr};
    nxt_on = on_ff;
    nxt_mode = mode_ff;
    nxt_min = min_ff;
    nxt_fresh = fresh_ff;
    nxt_done = done_ff;
    nxt_rep = rep_ff;
    nxt_hold = hold_ff;
    nxt_tick = tick_ff;
    nxt_beep = (beep_ff != 32'h0) ? beep_ff - 32'h1 : 32'h0;
    adj_step = 1'b0;
    fast = hold_ff >= HOLD_T;
    if (press[0]) begin
      nxt_on = ~on_ff;
      nxt_mode = SCT_IDLE;
      nxt_done = 1'b0;
    end
    if (s_ovf) begin
      nxt_on = 1'b0;
      nxt_mode = SCT_IDLE;
      nxt_beep = 32'h0;
    end
    if (on_ff && !s_ovf && !press[0]) begin
      if (press[1]) begin
        nxt_mode = (mode_ff == SCT_CONT) ? SCT_IDLE : SCT_CONT;
        if (mode_ff != SCT_CONT) nxt_min = ZERO_MIN;
        nxt_tick = 64'h0;
        nxt_done = 1'b0;
      end else if (press[2]) begin
        nxt_done = 1'b0;
        nxt_tick = 64'h0;
        if (mode_ff == SCT_TIMED) nxt_mode = SCT_IDLE;
        else if (fresh_ff && min_ff != ZERO_MIN) begin
          nxt_mode = SCT_TIMED;
          nxt_fresh = 1'b0;
        end
      end
      if (mode_ff == SCT_IDLE && (s_up ^ s_dn)) begin
        if (press[3] || press[4]) begin
          adj_step = 1'b1;
          nxt_rep = 32'h0;
          nxt_hold = 32'h0;
        end else begin
          nxt_hold = fast ? hold_ff : hold_ff + 32'h1;
          if (rep_ff >= (fast ? FAST_T : SLOW_T) - 1) begin
            adj_step = 1'b1;
            nxt_rep = 32'h0;
          end else nxt_rep = rep_ff + 32'h1;
        end
        if (adj_step) begin
          nxt_done = 1'b0;
          nxt_fresh = 1'b1;
          if (s_up && min_ff < MAX_MIN) nxt_min = min_ff + 7'h01;
          if (s_dn && min_ff > ZERO_MIN) nxt_min = min_ff - 7'h01;
        end
      end
    end
    // one count per minute hot; hold when cold
    if (counting) begin
      if (tick_ff >= MINUTE_T - 64'h1) begin
        nxt_tick = 64'h0;
        if (mode_ff == SCT_TIMED) begin
          nxt_min = min_ff - 7'h01;
          if (min_ff == 7'h01) begin
            nxt_mode = SCT_IDLE;
            nxt_done = 1'b1;
            nxt_beep = 32'(BEEP_T);
          end
        end else if (min_ff < MAX_MIN) nxt_min = min_ff + 7'h01;
      end else nxt_tick = tick_ff + 64'h1;
    end
    if (!nxt_on) begin
      nxt_mode = SCT_IDLE;
    end
  end

  // count only at temperature; steam gating
  assign steam_ok = on_ff && !s_ovf && !s_low && !s_door && mode_ff != SCT_IDLE;
  assign counting = steam_ok && s_hot && !press[1] && !press[2] && !press[0];

  // =====================================================
  // outputs
  always_comb begin
    nxt_lp = on_ff;
    nxt_lc = on_ff && mode_ff == SCT_CONT;
    nxt_lt = on_ff && mode_ff == SCT_TIMED;
    // flash when counting; steady when cold
    nxt_ls = (mode_ff != SCT_IDLE && on_ff) && (counting ? flash_ff : 1'b1);
    nxt_lo = s_ovf && flash_ff;
    nxt_lw = on_ff && !s_ovf && s_low;
    nxt_fv = on_ff && !s_ovf && s_low;
    nxt_ht = steam_ok;
    nxt_cd = steam_ok;
    nxt_bp = (beep_ff != 32'h0) && beep_ff[BEEP_BIT];
    nxt_bl = !on_ff || (done_ff && !flash_ff);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lp_ff <= 1'b0;
      lc_ff <= 1'b0;
      lt_ff <= 1'b0;
      ls_ff <= 1'b0;
      lo_ff <= 1'b0;
      lw_ff <= 1'b0;
      fv_ff <= 1'b0;
      ht_ff <= 1'b0;
      cd_ff <= 1'b0;
      bp_ff <= 1'b0;
      bl_ff <= 1'b1;
    end else begin
      lp_ff <= nxt_lp;
      lc_ff <= nxt_lc;
      lt_ff <= nxt_lt;
      ls_ff <= nxt_ls;
      lo_ff <= nxt_lo;
      lw_ff <= nxt_lw;
      fv_ff <= nxt_fv;
      ht_ff <= nxt_ht;
      cd_ff <= nxt_cd;
      bp_ff <= nxt_bp;
      bl_ff <= nxt_bl;
    end
  end

  // =====================================================
  // flash timer
  // one shared phase keeps every flashing output in step
  always_comb begin
    nxt_flash_cnt = flash_cnt_ff + 32'h1;
    nxt_flash = flash_ff;
    if (flash_cnt_ff >= FLASH_T - 1) begin
      nxt_flash_cnt = 32'h0;
      nxt_flash = ~flash_ff;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flash_cnt_ff <= 32'h0;
      flash_ff <= 1'b0;
    end else begin
      flash_cnt_ff <= nxt_flash_cnt;
      flash_ff <= nxt_flash;
    end
  end

  // =====================================================
  // sequencing registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      keys_ff <= 5'h1F;
      on_ff <= 1'b0;
      mode_ff <= SCT_IDLE;
      min_ff <= ZERO_MIN;
      fresh_ff <= 1'b0;
      done_ff <= 1'b0;
      rep_ff <= 32'h0;
      hold_ff <= 32'h0;
      tick_ff <= 64'h0;
      beep_ff <= 32'h0;
    end else begin
      keys_ff <= nxt_keys;
      on_ff <= nxt_on;
      mode_ff <= nxt_mode;
      min_ff <= nxt_min;
      fresh_ff <= nxt_fresh;
      done_ff <= nxt_done;
      rep_ff <= nxt_rep;
      hold_ff <= nxt_hold;
      tick_ff <= nxt_tick;
      beep_ff <= nxt_beep;
    end
  end

  assign lamp_power = lp_ff;
  assign lamp_cont = lc_ff;
  assign lamp_timed = lt_ff;
  assign lamp_status = ls_ff;
  assign lamp_overflow = lo_ff;
  assign lamp_water = lw_ff;
  assign fill_valve = fv_ff;
  assign heater_on = ht_ff;
  assign condenser_on = cd_ff;
  assign beeper = bp_ff;
  assign minutes = min_ff;
  assign display_blank = bl_ff;
endmodule : sct_cook_timer

// [testbench/sct_checker.sv]
// Purpose: port assertions for the cook timer
// Assumes: inputs pass two sync flops, act within 4 cycles
// Notes: bound into every sct_cook_timer instance
module sct_checker import sct_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire logic door_open,
  input wire logic level_low,
  input wire logic overflow,
  input wire logic lamp_power,
  input wire logic lamp_cont,
  input wire logic lamp_timed,
  input wire logic lamp_water,
  input wire logic fill_valve,
  input wire logic heater_on,
  input wire logic condenser_on,
  input wire logic [6:0] minutes
);
  // ==========
  // properties
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // five cycles covers sync plus output register
  sequence s_flood;
    overflow [*5];
  endsequence
  sequence s_door;
    door_open [*5];
  endsequence
  a_valve_lamp: assert property (fill_valve == lamp_water) else $error("valve and lamp differ");
  a_flood_off: assert property (s_flood |-> !lamp_power) else $error("unit on in flood");
  a_flood_valve: assert property (s_flood |-> !fill_valve) else $error("valve open in flood");
  a_modes_excl: assert property (!(lamp_cont && lamp_timed)) else $error("both modes lit");
  a_mode_on: assert property ((lamp_cont || lamp_timed) |-> lamp_power) else $error("mode while off");
  a_minute_cap: assert property (minutes <= MAX_MIN) else $error("minutes above cap");
  a_door_stop: assert property (s_door |-> !heater_on && !condenser_on) else $error("steam door open");
  a_low_stop: assert property (level_low [*5] |-> !heater_on) else $error("heater on low water");
  a_off_cold: assert property (!lamp_power [*2] |-> !heater_on) else $error("heater on while off");
endmodule : sct_checker

bind sct_cook_timer sct_checker chk (.clock(clock), .rst(rst), .door_open(door_open),
  .level_low(level_low), .overflow(overflow), .lamp_power(lamp_power), .lamp_cont(lamp_cont),
  .lamp_timed(lamp_timed), .lamp_water(lamp_water), .fill_valve(fill_valve), .heater_on(heater_on),
  .condenser_on(condenser_on), .minutes(minutes));

// [testbench/sct_panel.sv]
// Purpose: operator keys and cooker sensors
// Assumes: changes land 1 ns after a rising edge
// Notes: tasks are called from the bench
module sct_panel (
  input wire logic clock,
  output logic [4:0] keys,
  output logic [3:0] sens
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    keys = 5'h00;
    sens = 4'h0;
  end
  task automatic key(input int i, input int n);
    @(posedge clock);
    #1 keys[i] = 1'b1;
    repeat (n) @(posedge clock);
    #1 keys[i] = 1'b0;
    repeat (6) @(posedge clock);
    #1;
  endtask : key
  task automatic set(input int i, input logic v);
    @(posedge clock);
    #1 sens[i] = v;
  endtask : set
endmodule : sct_panel

// [testbench/tb_top.sv]
// Purpose: self-checking bench for the cook timer
// Assumes: shortened timing parameters
// Notes: panel model drives every key and sensor
module tb_top import sct_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // signals
  logic clock, rst, lp, lc, lt, ls, lo, lw, fv, ho, co, bp, db, seen, gone;
  logic [4:0] keys;
  logic [3:0] sens;
  logic [6:0] mins, m0;
  int mismatches, total_checks, cycles;
  sct_panel pnl (.clock(clock), .keys(keys), .sens(sens));
  // full-length beep: its tone bit is high from the start of the window
  sct_cook_timer #(.SLOW_T(10), .FAST_T(2), .HOLD_T(50), .FLASH_T(4), .MINUTE_T(64'h64)) dut (
    .clock(clock), .rst(rst), .key_power(keys[0]), .key_cont(keys[1]), .key_timed(keys[2]),
    .key_up(keys[3]), .key_down(keys[4]), .door_open(sens[0]), .level_low(sens[1]), .at_temp(sens[2]),
    .overflow(sens[3]), .lamp_power(lp), .lamp_cont(lc), .lamp_timed(lt), .lamp_status(ls),
    .lamp_overflow(lo), .lamp_water(lw), .fill_valve(fv), .heater_on(ho), .condenser_on(co),
    .beeper(bp), .minutes(mins), .display_blank(db));
  // ==========
  // helpers
  initial clock = 1'b0;
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic peek(ref logic s);
    seen = 1'b0;
    gone = 1'b0;
    repeat (10) begin
      cyc(1);
      seen = seen | s;
      gone = gone | ~s;
    end
  endtask : peek
  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_min(input string nm, input logic [6:0] e, input logic [6:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_min
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  // ==========
  // scenarios
  task automatic t_timed();
    pnl.key(0, 3);
    chk_bit("lamp_power", 1'b1, lp);
    pnl.key(3, 3);
    pnl.key(3, 3);
    chk_min("set", 7'h02, mins);
    pnl.key(2, 3);
    chk_bit("lamp_timed", 1'b1, lt);
    pnl.key(2, 3);
    chk_bit("timed cancel", 1'b0, lt);
    pnl.key(2, 3);
    chk_bit("no fresh time", 1'b0, lt);
    pnl.key(3, 3);
    pnl.key(4, 3);
    chk_min("trimmed", 7'h02, mins);
    pnl.key(2, 3);
    chk_bit("timed again", 1'b1, lt);
    cyc(250);
    chk_min("held", 7'h02, mins);
    chk_bit("steady status", 1'b1, ls);
    chk_bit("heater", 1'b1, ho);
    chk_bit("condenser", 1'b1, co);
    pnl.set(2, 1'b1);
    cyc(230);
    chk_min("expired", 7'h00, mins);
    chk_bit("timed off", 1'b0, lt);
    chk_bit("status off", 1'b0, ls);
    chk_bit("beeper", 1'b1, bp);
    peek(db);
    chk_bit("blink", 1'b1, seen);
    chk_bit("blink shown", 1'b1, gone);
    pnl.key(2, 3);
    chk_bit("stale time", 1'b0, lt);
  endtask : t_timed
  task automatic t_cont();
    pnl.key(3, 3);
    pnl.key(1, 3);
    chk_bit("lamp_cont", 1'b1, lc);
    chk_min("cleared", 7'h00, mins);
    cyc(110);
    chk_min("elapsed", 7'h01, mins);
    peek(ls);
    chk_bit("status lit", 1'b1, seen);
    chk_bit("status dark", 1'b1, gone);
    pnl.set(0, 1'b1);
    cyc(8);
    chk_bit("door heater", 1'b0, ho);
    chk_bit("door condenser", 1'b0, co);
    pnl.set(0, 1'b0);
    cyc(8);
    chk_bit("resumed", 1'b1, ho);
    pnl.set(1, 1'b1);
    cyc(8);
    chk_bit("water lamp", 1'b1, lw);
    chk_bit("fill valve", 1'b1, fv);
    chk_bit("low heater", 1'b0, ho);
    pnl.set(1, 1'b0);
    cyc(8);
    chk_bit("water off", 1'b0, lw);
  endtask : t_cont
  task automatic t_flood();
    pnl.set(3, 1'b1);
    cyc(8);
    chk_bit("flood off", 1'b0, lp);
    chk_bit("flood mode", 1'b0, lc);
    peek(lo);
    chk_bit("flood lamp", 1'b1, seen);
    chk_bit("flood lamp dark", 1'b1, gone);
    pnl.key(0, 3);
    chk_bit("power refused", 1'b0, lp);
    pnl.set(3, 1'b0);
    cyc(8);
  endtask : t_flood
  task automatic t_cap();
    pnl.key(0, 3);
    m0 = mins;
    pnl.key(3, 45);
    chk_min("slow rate", m0 + 7'h05, mins);
    pnl.key(3, 500);
    chk_min("cap", MAX_MIN, mins);
    pnl.key(4, 3);
    chk_min("trim", 7'h62, mins);
    pnl.key(0, 3);
    chk_bit("power off", 1'b0, lp);
  endtask : t_cap
  initial begin
    rst = 1'b1;
    repeat (8) @(posedge clock);
    #1 rst = 1'b0;
    cyc(2);
    chk_bit("blank at reset", 1'b1, db);
    t_timed();
    t_cont();
    t_flood();
    t_cap();
    wrap_up();
  end
endmodule : tb_top
